// >>> inc/xon_pkg.sv
// Purpose: shared constants for the flow-controlled serial receive node
// Assumes: 200 MHz core clock, 8N1 framing, least significant bit first
// Notes:   rates are kept in bits per second, periods are derived in the node
package xon_pkg;
  localparam int unsigned BYTE_W       = 8;                 // payload byte width
  localparam int unsigned RING_DEPTH   = 16;                // ring entries
  localparam int unsigned IDX_W        = 4;                 // ring index width
  localparam int unsigned PTR_W        = 5;                 // index plus wrap bit
  localparam int unsigned LOW_MARK     = 3;                 // free or stored threshold
  localparam int unsigned CNT_W        = 18;                // bit period counter width
  localparam int unsigned MEAS_W       = 21;                // span counter width
  localparam int unsigned MEAS_SHIFT   = 3;                 // span covers eight bits
  localparam int unsigned FRAME_BITS   = 10;                // start, eight data, stop
  localparam int unsigned CLK_HZ       = 32'h0BEB_C200;     // 200 MHz core clock
  localparam int unsigned INIT_BPS_DEF = 32'h0000_2580;     // 9600 bps start rate
  localparam int unsigned MIN_BPS_DEF  = 32'h0000_04B0;     // 1200 bps lowest rate
  localparam int unsigned MAX_BPS_DEF  = 32'h0004_C4B4;     // 312500 bps highest rate
  localparam logic [7:0]  XON_CODE     = 8'h11;             // sending allowed
  localparam logic [7:0]  XOFF_CODE    = 8'h13;             // sending stopped
  localparam logic [7:0]  CORR_CODE    = 8'h55;             // rate training byte
  localparam logic [2:0]  MEAS_EDGES   = 3'h4;              // falling edges after first
  localparam logic        correction_on_value  = 1'b1;      // training enabled
  localparam logic        correction_off_value = 1'b0;      // training skipped

  // node operating modes
  typedef enum logic [1:0] {
    MODE_MEASURE  = 2'b00,
    MODE_SEND_XON = 2'b01,
    MODE_RUN      = 2'b10
  } mode_e;

  // receiver framing states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_e;

  // true for a byte that collides with a flow code
  function automatic logic isFlowCode(input logic [7:0] b);
    isFlowCode = (b == XON_CODE) || (b == XOFF_CODE);
  endfunction : isFlowCode
endpackage : xon_pkg

// >>> design/ring_mem.sv
// Purpose: sixteen byte storage for the receive ring
// Assumes: one write and one read port on core_clk
// Notes:   read data is registered, valid the cycle after the address
`timescale 1ns/1ps
`default_nettype none
module ring_mem (
  input  wire logic                       core_clk,
  input  wire logic                       wrEn,
  input  wire logic [xon_pkg::IDX_W-1:0]  wrIdx,
  input  wire logic [xon_pkg::BYTE_W-1:0] wrData,
  input  wire logic [xon_pkg::IDX_W-1:0]  rdIdx,
  output logic      [xon_pkg::BYTE_W-1:0] rdData
);
  import xon_pkg::*;
  logic [BYTE_W-1:0] mem [RING_DEPTH];   // byte cells, no reset needed

  // write then registered read
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
    rdData <= mem[rdIdx];
  end
endmodule : ring_mem
`default_nettype wire

// >>> design/skid_buf2.sv
// Purpose: two-entry buffer between the ring and the byte consumer
// Assumes: valid and ready on both sides, same clock
// Notes:   out data comes straight from a register
`timescale 1ns/1ps
`default_nettype none
module skid_buf2 #(
  parameter int unsigned WIDTH = 9
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] slot0_r, slot0_nxt;  // head entry
  logic [WIDTH-1:0] slot1_r, slot1_nxt;  // second entry
  logic [1:0]       cnt_r, cnt_nxt;      // entries held

  assign inReady  = (cnt_r != 2'h2);
  assign outValid = (cnt_r != 2'h0);
  assign outData  = slot0_r;

  // pop shifts the second slot forward, push fills the first free slot
  always_comb begin
    slot0_nxt = slot0_r;
    slot1_nxt = slot1_r;
    cnt_nxt   = cnt_r;
    if (outValid && outReady) begin
      slot0_nxt = slot1_r;
      cnt_nxt   = cnt_nxt - 2'h1;
    end
    if (inValid && inReady) begin
      if (cnt_nxt == 2'h0) begin
        slot0_nxt = inData;
      end else begin
        slot1_nxt = inData;
      end
      cnt_nxt = cnt_nxt + 2'h1;
    end
  end

  // register the entries
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slot0_r <= '0;
      slot1_r <= '0;
      cnt_r   <= 2'h0;
    end else begin
      slot0_r <= slot0_nxt;
      slot1_r <= slot1_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  a_no_overfill: assert property (@(posedge core_clk) disable iff (rst)
    (cnt_r == 2'h2 && !outReady) |=> (cnt_r == 2'h2 && $stable(slot0_r)))
    else $error("buffer lost or moved a held word");
endmodule : skid_buf2
`default_nettype wire

// >>> design/xon_rx_node.sv
// Purpose: serial receive node with software flow control and rate training
// Assumes: peer obeys stop and go codes; one clock, async high reset
// Notes:   rate training measures the 0x55 training byte on the rx pin
// Operation
// (R1) sixteen entry ring, wrapping write and read
// (R2) send stop code at three free entries
// (R3) send go code at three stored entries
// (R4) peer sends 0x55; node measures, applies rate
// (R5) accept trained rates 1200 to 312500 only
// (R6) training selectable at build, on by default
// (R7) start rate configurable, default 9600
// (R8) flag data bytes that look like codes
// (R9) go code 0x11, stop code 0x13
// (R10) send go code after applying trained rate
// (R11) peer stops loading after current byte
// (R12) peer starts nothing new while stopped
`timescale 1ns/1ps
`default_nettype none
module xon_rx_node #(
  parameter logic        CORRECTION_SELECT = xon_pkg::correction_on_value, // see (R6)
  parameter int unsigned INIT_BPS          = xon_pkg::INIT_BPS_DEF,        // see (R7)
  parameter int unsigned MIN_BPS           = xon_pkg::MIN_BPS_DEF,
  parameter int unsigned MAX_BPS           = xon_pkg::MAX_BPS_DEF
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       rxdPin,
  output logic                            txdPin,
  output logic                            rdValid,
  input  wire logic                       rdReady,
  output logic      [xon_pkg::BYTE_W-1:0] rdData,
  output logic                            rdIsCode,
  output logic                            linkUp,
  output logic                            peerHeld
);
  import xon_pkg::*;

  // derived bit periods in core cycles
  localparam logic [CNT_W-1:0] INIT_PERIOD = CNT_W'(CLK_HZ / INIT_BPS);
  localparam logic [CNT_W-1:0] MIN_PERIOD  = CNT_W'(CLK_HZ / MAX_BPS);
  localparam logic [CNT_W-1:0] MAX_PERIOD  = CNT_W'(CLK_HZ / MIN_BPS);
  localparam logic [MEAS_W-1:0] MAX_SPAN   = MEAS_W'({MAX_PERIOD, 3'h0});
  localparam logic [PTR_W-1:0] HIGH_FILL   = PTR_W'(RING_DEPTH - LOW_MARK);
  localparam logic [PTR_W-1:0] LOW_FILL    = PTR_W'(LOW_MARK);
  localparam logic [PTR_W-1:0] FULL_FILL   = PTR_W'(RING_DEPTH);
  localparam logic [3:0]       FRAME_CNT   = 4'(FRAME_BITS);
  localparam mode_e            FIRST_MODE  = (CORRECTION_SELECT == correction_on_value) ?
                                             MODE_MEASURE : MODE_RUN;

  // input synchroniser
  logic rxMeta_r;                          // first stage, read only by next stage
  logic rxS_r;                             // synchronised line level
  logic rxPrev_r;                          // previous level for edge detect
  logic rxFall;                            // falling edge on the line

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxMeta_r <= 1'b1;
      rxS_r    <= 1'b1;
      rxPrev_r <= 1'b1;
    end else begin
      rxMeta_r <= rxdPin;
      rxS_r    <= rxMeta_r;
      rxPrev_r <= rxS_r;
    end
  end
  assign rxFall = rxPrev_r & ~rxS_r;

  // mode, rate training and flow state
  mode_e             mode_r, mode_nxt;         // node mode
  logic [CNT_W-1:0]  period_r, period_nxt;     // active bit period
  logic [MEAS_W-1:0] span_r, span_nxt;         // cycles since first training edge
  logic [2:0]        edges_r, edges_nxt;       // training edges seen
  logic              flowOff_r, flowOff_nxt;   // stop code sent, go not yet
  logic [CNT_W-1:0]  trained;                  // candidate period
  logic              trainOk;                  // candidate within limits
  logic              txGo;                     // launch a code this cycle
  logic [7:0]        txByte;                   // code to launch
  logic              txBusy_r;                 // transmitter active
  logic [PTR_W-1:0]  wrPtr_r, rdPtr_r;         // ring positions
  logic [PTR_W-1:0]  fill;                     // stored entries

  assign fill    = wrPtr_r - rdPtr_r;
  assign trained = CNT_W'(span_r >> MEAS_SHIFT);
  assign trainOk = (trained >= MIN_PERIOD) && (trained <= MAX_PERIOD);

  // next mode, trained period and flow codes
  always_comb begin
    mode_nxt    = mode_r;
    period_nxt  = period_r;
    span_nxt    = span_r + MEAS_W'(1);
    edges_nxt   = edges_r;
    flowOff_nxt = flowOff_r;
    txGo        = 1'b0;
    txByte      = XON_CODE;
    unique case (mode_r)
      MODE_MEASURE: begin
        // 0x55 gives five falling edges two bit times apart, eight bit times from first to last
        if (rxFall) begin
          if (edges_r == 3'h0) begin
            span_nxt  = MEAS_W'(1);                // count the edge cycle, span is whole bits
            edges_nxt = 3'h1;
          end else if (edges_r == MEAS_EDGES) begin
            edges_nxt = 3'h0;
            if (trainOk) begin
              period_nxt = trained;                // see (R4)
              mode_nxt   = MODE_SEND_XON;          // see (R5)
            end
          end else begin
            edges_nxt = edges_r + 3'h1;
          end
        end else if (edges_r != 3'h0 && span_r > MAX_SPAN) begin
          edges_nxt = 3'h0;                        // too slow, restart (R5)
        end
      end
      MODE_SEND_XON: begin
        // announce the new rate, then wait for an idle line
        if (!txBusy_r && edges_r == 3'h0) begin
          txGo      = 1'b1;                        // see (R10)
          txByte    = XON_CODE;                    // see (R9)
          edges_nxt = 3'h1;
        end else if (!txBusy_r && rxS_r) begin
          mode_nxt  = MODE_RUN;
          edges_nxt = 3'h0;
        end
      end
      MODE_RUN: begin
        if (!txBusy_r && !flowOff_r && fill >= HIGH_FILL) begin
          txGo        = 1'b1;                      // see (R2)
          txByte      = XOFF_CODE;                 // see (R9)
          flowOff_nxt = 1'b1;
        end else if (!txBusy_r && flowOff_r && fill <= LOW_FILL) begin
          txGo        = 1'b1;                      // see (R3)
          txByte      = XON_CODE;
          flowOff_nxt = 1'b0;
        end
      end
      default: begin
        mode_nxt = MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r    <= FIRST_MODE;                     // see (R6)
      period_r  <= INIT_PERIOD;                    // see (R7)
      span_r    <= '0;
      edges_r   <= 3'h0;
      flowOff_r <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      period_r  <= period_nxt;
      span_r    <= span_nxt;
      edges_r   <= edges_nxt;
      flowOff_r <= flowOff_nxt;
    end
  end

  // code transmitter
  logic [FRAME_BITS-1:0] txFrame_r, txFrame_nxt;   // bits still to send
  logic [3:0]            txBits_r, txBits_nxt;     // bits left in frame
  logic [CNT_W-1:0]      txCnt_r, txCnt_nxt;       // cycles left in bit
  logic                  txBusy_nxt;
  logic                  txd_r, txd_nxt;           // registered line level
  logic [7:0]            txLast_r, txLast_nxt;     // last code launched

  always_comb begin
    txFrame_nxt = txFrame_r;
    txBits_nxt  = txBits_r;
    txCnt_nxt   = txCnt_r;
    txBusy_nxt  = txBusy_r;
    txLast_nxt  = txLast_r;
    if (txGo) begin
      txFrame_nxt = {1'b1, txByte, 1'b0};
      txBits_nxt  = FRAME_CNT;
      txCnt_nxt   = period_r - CNT_W'(1);
      txBusy_nxt  = 1'b1;
      txLast_nxt  = txByte;
    end else if (txBusy_r) begin
      if (txCnt_r != '0) begin
        txCnt_nxt = txCnt_r - CNT_W'(1);
      end else if (txBits_r == 4'h1) begin
        txBusy_nxt = 1'b0;                         // stop bit done
      end else begin
        txFrame_nxt = {1'b1, txFrame_r[FRAME_BITS-1:1]};
        txBits_nxt  = txBits_r - 4'h1;
        txCnt_nxt   = period_r - CNT_W'(1);
      end
    end
    txd_nxt = txBusy_nxt ? txFrame_nxt[0] : 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txFrame_r <= '1;
      txBits_r  <= 4'h0;
      txCnt_r   <= '0;
      txBusy_r  <= 1'b0;
      txd_r     <= 1'b1;
      txLast_r  <= 8'h00;
    end else begin
      txFrame_r <= txFrame_nxt;
      txBits_r  <= txBits_nxt;
      txCnt_r   <= txCnt_nxt;
      txBusy_r  <= txBusy_nxt;
      txd_r     <= txd_nxt;
      txLast_r  <= txLast_nxt;
    end
  end
  assign txdPin = txd_r;

  // byte receiver, active only once the rate is settled
  rx_e              rxSt_r, rxSt_nxt;          // framing state
  logic [CNT_W-1:0] rxCnt_r, rxCnt_nxt;        // cycles to next sample
  logic [2:0]       rxBit_r, rxBit_nxt;        // data bit index
  logic [7:0]       rxSh_r, rxSh_nxt;          // assembling byte
  logic             rxDone;                    // whole byte with good stop bit

  always_comb begin
    rxSt_nxt  = rxSt_r;
    rxCnt_nxt = rxCnt_r;
    rxBit_nxt = rxBit_r;
    rxSh_nxt  = rxSh_r;
    rxDone    = 1'b0;
    if (rxCnt_r != '0) begin
      rxCnt_nxt = rxCnt_r - CNT_W'(1);
    end
    unique case (rxSt_r)
      RX_IDLE: begin
        if (mode_r == MODE_RUN && rxFall) begin
          rxSt_nxt  = RX_START;
          rxCnt_nxt = period_r >> 1;           // aim at mid bit
        end
      end
      RX_START: begin
        if (rxCnt_r == '0) begin
          rxSt_nxt  = rxS_r ? RX_IDLE : RX_DATA;  // glitch goes back idle
          rxCnt_nxt = period_r - CNT_W'(1);
          rxBit_nxt = 3'h0;
        end
      end
      RX_DATA: begin
        if (rxCnt_r == '0) begin
          rxSh_nxt  = {rxS_r, rxSh_r[7:1]};
          rxCnt_nxt = period_r - CNT_W'(1);
          rxBit_nxt = rxBit_r + 3'h1;
          if (rxBit_r == 3'h7) begin
            rxSt_nxt = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rxCnt_r == '0) begin
          rxDone   = rxS_r;                    // framing error drops the byte
          rxSt_nxt = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxSt_r  <= RX_IDLE;
      rxCnt_r <= '0;
      rxBit_r <= 3'h0;
      rxSh_r  <= 8'h00;
    end else begin
      rxSt_r  <= rxSt_nxt;
      rxCnt_r <= rxCnt_nxt;
      rxBit_r <= rxBit_nxt;
      rxSh_r  <= rxSh_nxt;
    end
  end

  // ring pointers and drain toward the output buffer
  logic [PTR_W-1:0]  wrPtr_nxt, rdPtr_nxt;
  logic              rdPend_r, rdPend_nxt;     // memory read in flight
  logic              ringWr;                   // store this cycle
  logic              bufReady;                 // output buffer has room
  logic [BYTE_W-1:0] memQ;                     // registered ring data

  always_comb begin
    ringWr     = rxDone && (fill != FULL_FILL);   // see (R1)
    wrPtr_nxt  = ringWr ? wrPtr_r + PTR_W'(1) : wrPtr_r;
    rdPend_nxt = (fill != '0) && !rdPend_r && bufReady;
    rdPtr_nxt  = rdPend_nxt ? rdPtr_r + PTR_W'(1) : rdPtr_r;  // see (R1)
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPtr_r  <= '0;
      rdPtr_r  <= '0;
      rdPend_r <= 1'b0;
    end else begin
      wrPtr_r  <= wrPtr_nxt;
      rdPtr_r  <= rdPtr_nxt;
      rdPend_r <= rdPend_nxt;
    end
  end

  ring_mem u_ring (
    .core_clk (core_clk),
    .wrEn     (ringWr),
    .wrIdx    (wrPtr_r[IDX_W-1:0]),
    .wrData   (rxSh_r),
    .rdIdx    (rdPtr_r[IDX_W-1:0]),
    .rdData   (memQ)
  );

  // code-like data is marked so the consumer can tell it apart
  logic [BYTE_W:0] bufIn;                      // flag and byte
  logic [BYTE_W:0] bufOut;
  assign bufIn = {isFlowCode(memQ), memQ};     // see (R8)

  skid_buf2 #(.WIDTH(BYTE_W + 1)) u_out (
    .core_clk (core_clk),
    .rst      (rst),
    .inValid  (rdPend_r),
    .inReady  (bufReady),
    .inData   (bufIn),
    .outValid (rdValid),
    .outReady (rdReady),
    .outData  (bufOut)
  );
  assign rdData   = bufOut[BYTE_W-1:0];
  assign rdIsCode = bufOut[BYTE_W];
  assign linkUp   = (mode_r == MODE_RUN);
  assign peerHeld = flowOff_r;

  // checks
  a_ring_bound: assert property (@(posedge core_clk) disable iff (rst)  // see (R1)
    fill <= FULL_FILL) else $error("ring holds more than sixteen");
  a_stop_sent: assert property (@(posedge core_clk) disable iff (rst)  // see (R2)
    (mode_r == MODE_RUN && !txBusy_r && !flowOff_r && fill >= HIGH_FILL)
    |=> (txBusy_r && flowOff_r && txLast_r == XOFF_CODE && !txd_r))
    else $error("stop code not launched at high fill");
  a_go_sent: assert property (@(posedge core_clk) disable iff (rst)  // see (R3)
    (mode_r == MODE_RUN && !txBusy_r && flowOff_r && fill <= LOW_FILL)
    |=> (txBusy_r && !flowOff_r && txLast_r == XON_CODE))
    else $error("go code not launched at low fill");
  a_rate_apply: assert property (@(posedge core_clk) disable iff (rst)  // see (R4)
    (mode_r == MODE_MEASURE && rxFall && edges_r == MEAS_EDGES && trainOk)
    |=> (mode_r == MODE_SEND_XON && period_r == $past(trained)))
    else $error("trained rate not applied");
  a_rate_limits: assert property (@(posedge core_clk) disable iff (rst)  // see (R5)
    $changed(period_r) |-> ($past(mode_r) == MODE_MEASURE && mode_r == MODE_SEND_XON))
    else $error("rate changed outside training");
  a_rate_range: assert property (@(posedge core_clk) disable iff (rst)  // see (R5)
    (mode_r == MODE_SEND_XON) |-> (period_r >= MIN_PERIOD && period_r <= MAX_PERIOD))
    else $error("trained rate out of range");
  a_first_mode: assert property (@(posedge core_clk) disable iff (rst)  // see (R6)
    $past(rst) |-> (mode_r == FIRST_MODE && !txBusy_r))
    else $error("wrong mode after reset");
  a_start_rate: assert property (@(posedge core_clk) disable iff (rst)  // see (R7)
    (mode_r == MODE_MEASURE) |-> (period_r == INIT_PERIOD))
    else $error("start rate disturbed before training");
  a_code_flag: assert property (@(posedge core_clk) disable iff (rst)  // see (R8)
    rdValid |-> (rdIsCode == isFlowCode(rdData)))
    else $error("code-like flag wrong");
  a_go_after_fix: assert property (@(posedge core_clk) disable iff (rst)  // see (R10)
    (mode_r == MODE_SEND_XON && !txBusy_r && edges_r == 3'h0)
    |=> (txBusy_r && txLast_r == XON_CODE) ##1 (!txd_r))
    else $error("go code not sent after training");
endmodule : xon_rx_node
`default_nettype wire

// >>> tb/peer_tx.sv
// Purpose: peer node that trains the rate and then streams queued bytes
// Assumes: fixed bit period in core_clk cycles, 8N1, lsb first
// Notes:   obeys stop and go codes decoded from its input line
`timescale 1ns/1ps
`default_nettype none
module peer_tx #(
  parameter int PER = 40 // bit period in cycles
) (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic codeLine,
  output var  logic txLine
);
  logic [7:0] txQ[$]; // bytes waiting to go out
  logic       sendOk; // go state of this peer
  int         xonCnt; // go codes seen
  int         xoffCnt; // stop codes seen
  logic [7:0] rxB; // code being decoded

  // one frame: start bit, eight data bits lsb first, stop bit
  task automatic sendFrame(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      txLine <= f[i];
      repeat (PER) @(posedge core_clk);
    end
  endtask : sendFrame

  // training byte first, then queued bytes while allowed
  initial begin
    txLine = 1'b1;
    @(negedge rst);
    repeat (4) @(posedge core_clk);
    sendFrame(8'h55);
    forever begin
      @(posedge core_clk);
      // the go state is looked at only between frames
      if (sendOk && txQ.size() > 0) sendFrame(txQ.pop_front());
    end
  end

  // decode returning codes, sampled in mid bit
  initial begin
    sendOk = 1'b0;
    xonCnt = 0;
    xoffCnt = 0;
    rxB = 8'h00;
    forever begin
      @(negedge codeLine);
      repeat (PER + PER / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        rxB[i] = codeLine;
        repeat (PER) @(posedge core_clk);
      end
      if (rxB == 8'h11) begin
        sendOk = 1'b1;
        xonCnt++;
      end else if (rxB == 8'h13) begin
        sendOk = 1'b0;
        xoffCnt++;
      end
    end
  end
endmodule : peer_tx
`default_nettype wire

// >>> tb/tb.sv
// Purpose: self-checking bench for the flow-controlled receive node
// Assumes: sim start rate gives a 40 cycle bit period
// Notes:   the consumer stalls to fill the ring, then drains it
`timescale 1ns/1ps
`default_nettype none
module tb;
  import xon_pkg::*;
  localparam int PER = 40; // bit period in cycles
  logic       core_clk;
  logic       rst;
  logic       rxdPin;
  logic       txdPin;
  logic       rdValid;
  logic       rdReady;
  logic [7:0] rdData;
  logic       rdIsCode;
  logic       linkUp;
  logic       peerHeld;
  logic       offTxd;    // code line of the node built without training
  logic       offLinkUp; // run state of the node built without training
  int         miscompares;
  int         n_tests;
  logic [7:0] sent[20]; // stream handed to the peer

  xon_rx_node #(.INIT_BPS(5000000), .MAX_BPS(10000000)) dut (
    .core_clk(core_clk), .rst(rst), .rxdPin(rxdPin), .txdPin(txdPin), .rdValid(rdValid),
    .rdReady(rdReady), .rdData(rdData), .rdIsCode(rdIsCode), .linkUp(linkUp), .peerHeld(peerHeld));
  peer_tx #(.PER(PER)) peer (.core_clk(core_clk), .rst(rst), .codeLine(txdPin), .txLine(rxdPin));
  // second node with training switched off, idle line, only its start-up behaviour is judged
  xon_rx_node #(.CORRECTION_SELECT(correction_off_value), .INIT_BPS(5000000), .MAX_BPS(10000000)) dutOff (
    .core_clk(core_clk), .rst(rst), .rxdPin(1'b1), .txdPin(offTxd), .rdValid(), .rdReady(1'b0),
    .rdData(), .rdIsCode(), .linkUp(offLinkUp), .peerHeld());

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // one compare for every kind of value, flags zero-extended
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // outputs idle during reset, then release
  task automatic t_reset();
    repeat (4) @(negedge core_clk);
    chk("txdPin", 8'h01, {7'h0, txdPin});
    chk("rdValid", 8'h00, {7'h0, rdValid});
    chk("linkUp", 8'h00, {7'h0, linkUp});
    chk("peerHeld", 8'h00, {7'h0, peerHeld});
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    $display("test reset done");
  endtask : t_reset

  // training byte measured, go code sent, nothing stored
  task automatic t_train();
    repeat (4) @(negedge core_clk);
    chk("offLinkUp", 8'h01, {7'h0, offLinkUp});
    chk("offTxd", 8'h01, {7'h0, offTxd});
    for (int i = 0; i < 4000 && linkUp !== 1'b1; i++) @(negedge core_clk);
    chk("linkUp", 8'h01, {7'h0, linkUp});
    repeat (12 * PER) @(negedge core_clk);
    chk("goCount", 8'h01, 8'(peer.xonCnt));
    chk("rdValid", 8'h00, {7'h0, rdValid});
    $display("test train done");
  endtask : t_train

  // consumer stalls; ring fills, stop code goes out, peer holds back
  task automatic t_fill();
    int q;
    for (int i = 0; i < 20; i++) sent[i] = 8'h30 + 8'(i);
    sent[5] = 8'h11;
    sent[9] = 8'h13;
    for (int i = 0; i < 20; i++) peer.txQ.push_back(sent[i]);
    for (int i = 0; i < 20000 && peerHeld !== 1'b1; i++) @(negedge core_clk);
    chk("peerHeld", 8'h01, {7'h0, peerHeld});
    chk("lateStop", 8'h01, {7'h0, peer.txQ.size() <= 7});
    chk("earlyStop", 8'h01, {7'h0, peer.txQ.size() >= 3});
    repeat (30 * PER) @(negedge core_clk);
    q = peer.txQ.size();
    chk("stopCount", 8'h01, 8'(peer.xoffCnt));
    chk("rdData", sent[0], rdData);
    repeat (30 * PER) @(negedge core_clk);
    chk("heldBack", 8'(q), 8'(peer.txQ.size()));
    chk("rdValid", 8'h01, {7'h0, rdValid});
    $display("test fill done");
  endtask : t_fill

  // drain in order through the wrap; go code resumes the peer
  task automatic t_drain();
    int k;
    k = 0;
    @(posedge core_clk);
    rdReady <= 1'b1;
    for (int i = 0; i < 30000 && k < 20; i++) begin
      @(negedge core_clk);
      if (rdValid === 1'b1) begin
        chk("rdData", sent[k], rdData);
        chk("rdIsCode", {7'h0, sent[k] == 8'h11 || sent[k] == 8'h13}, {7'h0, rdIsCode});
        k++;
      end
    end
    chk("drained", 8'h14, 8'(k));
    repeat (20 * PER) @(negedge core_clk);
    chk("rdValid", 8'h00, {7'h0, rdValid});
    chk("goCount", 8'h02, 8'(peer.xonCnt));
    chk("peerHeld", 8'h00, {7'h0, peerHeld});
    $display("test drain done");
  endtask : t_drain

  // main sequence
  initial begin
    rst = 1'b1;
    rdReady = 1'b0;
    miscompares = 0;
    n_tests = 0;
    t_reset();
    t_train();
    t_fill();
    t_drain();
    give_verdict();
  end

  // hang guard, well beyond the expected run
  initial begin
    #400000;
    miscompares++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
